// *** include/mmfc_pkg.sv ***
package mmfc_pkg;

    // counter width and status byte width
    localparam int CNT_W = 32;
    localparam int STAT_W = 8;

    // register byte addresses on the wishbone slave
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_PRESET0 = 8'h04;
    localparam logic [7:0] ADDR_END0    = 8'h08;
    localparam logic [7:0] ADDR_PRESET1 = 8'h0C;
    localparam logic [7:0] ADDR_END1    = 8'h10;
    localparam logic [7:0] ADDR_COUNT0  = 8'h14;
    localparam logic [7:0] ADDR_COUNT1  = 8'h18;
    localparam logic [7:0] ADDR_STATUS  = 8'h1C;

    // control register fields
    localparam int CTRL_MODE_LSB  = 0;
    localparam int CTRL_DIR0_BIT  = 4;
    localparam int CTRL_DIR1_BIT  = 5;
    localparam int CTRL_LOAD0_BIT = 8;
    localparam int CTRL_LOAD1_BIT = 9;

    // status byte fields
    localparam int STAT_END0_BIT = 0;
    localparam int STAT_END1_BIT = 1;
    localparam int STAT_SET_BIT  = 2;

    // reset values
    localparam logic [3:0]       MODE_RST   = 4'h0;
    localparam logic [CNT_W-1:0] PRESET_RST = 32'h0000_0000;
    localparam logic [CNT_W-1:0] END_RST    = 32'hFFFF_FFFF;
    localparam logic [CNT_W-1:0] COUNT_RST  = 32'h0000_0000;

    typedef enum logic [3:0] {
        MMFC_OFF      = 4'h0,
        MMFC_UP_END   = 4'h1,
        MMFC_UP_GATE  = 4'h2,
        MMFC_DUAL     = 4'h3,
        MMFC_DUAL_INV = 4'h4,
        MMFC_SET_RISE = 4'h5,
        MMFC_SET_FALL = 4'h6,
        MMFC_QUAD_X1  = 4'h7,
        MMFC_UNUSED   = 4'h8,
        MMFC_QUAD_X2  = 4'h9,
        MMFC_QUAD_X4  = 4'hA
    } mmfc_mode_e;

    typedef struct packed {
        logic       dir1;
        logic       dir0;
        logic [3:0] mode;
    } mmfc_ctrl_s;

    typedef struct packed {
        logic en;
        logic down;
    } mmfc_step_s;

endpackage

// *** logic/mmfc_sync.sv ***
`timescale 1ns/1ps

module mmfc_sync #(
    parameter int W = 2
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // asynchronous pins and their synchronised copy
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    logic [W-1:0] meta;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta   <= '0;
            sync_o <= '0;
        end else begin
            meta   <= async_i;
            sync_o <= meta;
        end
    end

endmodule

// *** logic/mmfc_counter.sv ***
`timescale 1ns/1ps

module mmfc_counter (
    // clock and reset
    input  wire logic                        clk_i,
    input  wire logic                        rst_i,
    // control
    input  wire logic                        load_i,
    input  wire logic [mmfc_pkg::CNT_W-1:0]  preset_i,
    input  wire mmfc_pkg::mmfc_step_s        step_i,
    input  wire logic [mmfc_pkg::CNT_W-1:0]  end_value_i,
    // state
    output logic      [mmfc_pkg::CNT_W-1:0]  count_o,
    output logic                             hit_o
);

    logic [mmfc_pkg::CNT_W-1:0] next_count;
    logic [mmfc_pkg::CNT_W-1:0] stepped;

    assign stepped = step_i.down ? count_o - 32'h0000_0001 : count_o + 32'h0000_0001;

    // a load wins over a count step in the same cycle; counting resumes from the preset
    assign next_count = load_i ? preset_i : (step_i.en ? stepped : count_o);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count_o <= mmfc_pkg::COUNT_RST;
            hit_o   <= 1'b0;
        end else begin
            count_o <= next_count;
            hit_o   <= step_i.en && !load_i && (stepped == end_value_i);
        end
    end

endmodule

// *** logic/mmfc_top.sv ***
// Notes on behaviour
// - mode 1: one up-counter on input 0, end-value shown on the output channel
// - mode 2: up-count only while input 1 gate is high, end-value on output
// - mode 3: two independent up/down counters on inputs 0 and 1, no output
// - mode 4: as mode 3 but counter 1 counts its inverted input
// - mode 5: one up/down counter, rising edge of set input loads preset
// - mode 6: one up/down counter, falling edge of set input loads preset
// - up/down modes report end-value only as a status flag, never on output
// - mode 7: quadrature decode of tracks A and B, direction from phase
// - mode 7: single evaluation, one count per cycle, end-value via status
// - quadrature modes ignore any index track; only A and B count
// - mode 9: count both edges of track A, double counts per cycle
// - mode 10: count both edges of A and B, fourfold counts
`timescale 1ns/1ps

module mmfc_top (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // counting inputs: 0 = count / track A, 1 = gate / second count / set / track B
    input  wire logic [1:0]  input_channel_i,
    // end-value output channel and channel ownership
    output logic             configurable_io_channel_o,
    output logic             io_channel_claim_o,
    output logic      [1:0]  input_claim_o
);

    // byte-lane merge for writes
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic rose(input logic cur, input logic prev);
        return cur && !prev;
    endfunction

    function automatic logic fell(input logic cur, input logic prev);
        return !cur && prev;
    endfunction

    // quadrature step: bit 0 is track A, bit 1 is track B; a change on both
    // tracks in one sample is a lost step and is dropped
    function automatic mmfc_pkg::mmfc_step_s quad_step(input logic [1:0] cur,
                                                       input logic [1:0] prev,
                                                       input logic [3:0] mode);
        mmfc_pkg::mmfc_step_s s;
        logic a_ch;
        logic b_ch;
        s.en = 1'b0;
        s.down = 1'b0;
        a_ch = (cur[0] != prev[0]) && (cur[1] == prev[1]);
        b_ch = (cur[1] != prev[1]) && (cur[0] == prev[0]);
        unique case (mode)
            mmfc_pkg::MMFC_QUAD_X1: begin
                s.en = a_ch && cur[0];
                s.down = cur[1];
            end
            mmfc_pkg::MMFC_QUAD_X2: begin
                s.en = a_ch;
                s.down = cur[0] ? cur[1] : !cur[1];
            end
            mmfc_pkg::MMFC_QUAD_X4: begin
                s.en = a_ch || b_ch;
                if (a_ch) begin
                    s.down = cur[0] ? cur[1] : !cur[1];
                end else begin
                    s.down = cur[1] ? !cur[0] : cur[0];
                end
            end
            default: begin
                s.en = 1'b0;
            end
        endcase
        return s;
    endfunction

    // registers
    mmfc_pkg::mmfc_ctrl_s         ctrl;
    logic [mmfc_pkg::CNT_W-1:0]   preset0;
    logic [mmfc_pkg::CNT_W-1:0]   preset1;
    logic [mmfc_pkg::CNT_W-1:0]   end0;
    logic [mmfc_pkg::CNT_W-1:0]   end1;
    logic [mmfc_pkg::STAT_W-1:0]  status;
    logic                         load0_pulse;
    logic                         load1_pulse;

    // synchronised inputs and their previous sample
    logic [1:0] in_q;
    logic [1:0] in_d;

    // counter wiring
    mmfc_pkg::mmfc_step_s         step0;
    mmfc_pkg::mmfc_step_s         step1;
    mmfc_pkg::mmfc_step_s         q_step;
    logic [mmfc_pkg::CNT_W-1:0]   count0;
    logic [mmfc_pkg::CNT_W-1:0]   count1;
    logic                         hit0;
    logic                         hit1;
    logic                         set_edge;
    logic                         load0;

    // mode decode
    logic m_up;
    logic m_gate;
    logic m_dual;
    logic m_inv;
    logic m_set;
    logic m_quad;
    logic m_active;

    assign m_up     = ctrl.mode == mmfc_pkg::MMFC_UP_END;
    assign m_gate   = ctrl.mode == mmfc_pkg::MMFC_UP_GATE;
    assign m_dual   = (ctrl.mode == mmfc_pkg::MMFC_DUAL) || m_inv;
    assign m_inv    = ctrl.mode == mmfc_pkg::MMFC_DUAL_INV;
    assign m_set    = (ctrl.mode == mmfc_pkg::MMFC_SET_RISE)
                   || (ctrl.mode == mmfc_pkg::MMFC_SET_FALL);
    assign m_quad   = (ctrl.mode == mmfc_pkg::MMFC_QUAD_X1)
                   || (ctrl.mode == mmfc_pkg::MMFC_QUAD_X2)
                   || (ctrl.mode == mmfc_pkg::MMFC_QUAD_X4);
    // modes 0, 8 and codes above 10 leave everything idle
    assign m_active = m_up || m_gate || m_dual || m_set || m_quad;

    // wishbone decode
    logic        bus_req;
    logic        wr_en;
    logic        wr_ctrl;
    logic        wr_status;
    logic [31:0] ctrl_word;
    logic [31:0] ctrl_new;
    logic [31:0] rd_data;

    assign bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_en     = bus_req && wb_we_i;
    assign wr_ctrl   = wr_en && (wb_adr_i == mmfc_pkg::ADDR_CTRL);
    assign wr_status = wr_en && (wb_adr_i == mmfc_pkg::ADDR_STATUS) && wb_sel_i[0];

    assign ctrl_word = {26'h000_0000, ctrl.dir1, ctrl.dir0, ctrl.mode};
    assign ctrl_new  = merge(ctrl_word, wb_dat_i, wb_sel_i);

    always_comb begin
        unique case (wb_adr_i)
            mmfc_pkg::ADDR_CTRL:    rd_data = ctrl_word;
            mmfc_pkg::ADDR_PRESET0: rd_data = preset0;
            mmfc_pkg::ADDR_END0:    rd_data = end0;
            mmfc_pkg::ADDR_PRESET1: rd_data = preset1;
            mmfc_pkg::ADDR_END1:    rd_data = end1;
            mmfc_pkg::ADDR_COUNT0:  rd_data = count0;
            mmfc_pkg::ADDR_COUNT1:  rd_data = count1;
            mmfc_pkg::ADDR_STATUS:  rd_data = {24'h00_0000, status};
            default:                rd_data = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? rd_data : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl.mode   <= mmfc_pkg::MODE_RST;
            ctrl.dir0   <= 1'b0;
            ctrl.dir1   <= 1'b0;
            load0_pulse <= 1'b0;
            load1_pulse <= 1'b0;
        end else begin
            load0_pulse <= wr_ctrl && ctrl_new[mmfc_pkg::CTRL_LOAD0_BIT];
            load1_pulse <= wr_ctrl && ctrl_new[mmfc_pkg::CTRL_LOAD1_BIT];
            if (wr_ctrl) begin
                ctrl.mode <= ctrl_new[mmfc_pkg::CTRL_MODE_LSB +: 4];
                ctrl.dir0 <= ctrl_new[mmfc_pkg::CTRL_DIR0_BIT];
                ctrl.dir1 <= ctrl_new[mmfc_pkg::CTRL_DIR1_BIT];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            preset0 <= mmfc_pkg::PRESET_RST;
            preset1 <= mmfc_pkg::PRESET_RST;
            end0    <= mmfc_pkg::END_RST;
            end1    <= mmfc_pkg::END_RST;
        end else if (wr_en) begin
            if (wb_adr_i == mmfc_pkg::ADDR_PRESET0) begin
                preset0 <= merge(preset0, wb_dat_i, wb_sel_i);
            end
            if (wb_adr_i == mmfc_pkg::ADDR_END0) begin
                end0 <= merge(end0, wb_dat_i, wb_sel_i);
            end
            if (wb_adr_i == mmfc_pkg::ADDR_PRESET1) begin
                preset1 <= merge(preset1, wb_dat_i, wb_sel_i);
            end
            if (wb_adr_i == mmfc_pkg::ADDR_END1) begin
                end1 <= merge(end1, wb_dat_i, wb_sel_i);
            end
        end
    end

    // input pins cross into the clock domain before any edge logic sees them
    mmfc_sync #(
        .W       (2)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .async_i (input_channel_i),
        .sync_o  (in_q)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            in_d <= 2'h0;
        end else begin
            in_d <= in_q;
        end
    end

    // quadrature decode reads only tracks A and B; no index input exists
    assign q_step = quad_step(in_q, in_d, ctrl.mode);

    // counter 0 step selection
    always_comb begin
        step0.en   = 1'b0;
        step0.down = 1'b0;
        if (m_up) begin
            step0.en = rose(in_q[0], in_d[0]);
        end else if (m_gate) begin
            step0.en = rose(in_q[0], in_d[0]) && in_q[1];
        end else if (m_dual || m_set) begin
            step0.en   = rose(in_q[0], in_d[0]);
            step0.down = ctrl.dir0;
        end else if (m_quad) begin
            step0 = q_step;
        end
    end

    // counter 1 only runs in the two-counter modes; mode 4 counts the inverted input
    always_comb begin
        step1.down = ctrl.dir1;
        if (m_inv) begin
            step1.en = fell(in_q[1], in_d[1]);
        end else begin
            step1.en = m_dual && rose(in_q[1], in_d[1]);
        end
    end

    // dynamic set on the chosen edge of input 1
    assign set_edge = (ctrl.mode == mmfc_pkg::MMFC_SET_RISE) ? rose(in_q[1], in_d[1])
                    : (ctrl.mode == mmfc_pkg::MMFC_SET_FALL) && fell(in_q[1], in_d[1]);
    assign load0 = set_edge || load0_pulse;

    mmfc_counter u_cnt0 (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .load_i      (load0),
        .preset_i    (preset0),
        .step_i      (step0),
        .end_value_i (end0),
        .count_o     (count0),
        .hit_o       (hit0)
    );

    mmfc_counter u_cnt1 (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .load_i      (load1_pulse),
        .preset_i    (preset1),
        .step_i      (step1),
        .end_value_i (end1),
        .count_o     (count1),
        .hit_o       (hit1)
    );

    // sticky status flags, write 1 to clear; a new event in the clear cycle wins
    logic [mmfc_pkg::STAT_W-1:0] stat_set;
    logic [mmfc_pkg::STAT_W-1:0] stat_clr;

    always_comb begin
        stat_set = '0;
        stat_set[mmfc_pkg::STAT_END0_BIT] = hit0 && m_active;
        stat_set[mmfc_pkg::STAT_END1_BIT] = hit1 && m_dual;
        stat_set[mmfc_pkg::STAT_SET_BIT]  = set_edge;
    end

    assign stat_clr = wr_status ? wb_dat_i[mmfc_pkg::STAT_W-1:0] : '0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status <= '0;
        end else begin
            status <= (status & ~stat_clr) | stat_set;
        end
    end

    // output channel only in modes 1 and 2; up/down modes keep it free
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            configurable_io_channel_o <= 1'b0;
            io_channel_claim_o        <= 1'b0;
            input_claim_o             <= 2'h0;
        end else begin
            configurable_io_channel_o <= (m_up || m_gate)
                                         && status[mmfc_pkg::STAT_END0_BIT];
            io_channel_claim_o        <= m_up || m_gate;
            input_claim_o             <= m_up ? 2'h1 : (m_active ? 2'h3 : 2'h0);
        end
    end

endmodule

// *** test/mmfc_monitor.sv ***
`timescale 1ns/1ps

module mmfc_monitor (
    // clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    // wishbone slave
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // counting side
    input wire logic [1:0]  input_channel_i,
    input wire logic        configurable_io_channel_o,
    input wire logic        io_channel_claim_o,
    input wire logic [1:0]  input_claim_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_ack_next;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack missing");

    property p_ack_pulse;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");

    property p_ack_cause;
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");

    property p_dat_idle;
        !wb_ack_o |-> wb_dat_o == 32'h0000_0000;
    endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("read data not idle");

    property p_reset_out;
        $past(rst_i) |-> !wb_ack_o && !configurable_io_channel_o && !io_channel_claim_o
            && input_claim_o == 2'b00;
    endproperty
    a_reset_out: assert property (p_reset_out) else $error("outputs not cleared");

    property p_out_owned;
        configurable_io_channel_o |-> io_channel_claim_o;
    endproperty
    a_out_owned: assert property (p_out_owned) else $error("output not claimed");

    property p_single_in;
        input_claim_o == 2'b01 |-> io_channel_claim_o;
    endproperty
    a_single_in: assert property (p_single_in) else $error("mode one claim");

    property p_out_needs_in;
        io_channel_claim_o |-> input_claim_o[0];
    endproperty
    a_out_needs_in: assert property (p_out_needs_in) else $error("claim pairing");

    property p_no_claim;
        input_claim_o == 2'b00 |-> !io_channel_claim_o && !configurable_io_channel_o;
    endproperty
    a_no_claim: assert property (p_no_claim) else $error("idle mode claims");

    property p_claim_code;
        input_claim_o != 2'b10;
    endproperty
    a_claim_code: assert property (p_claim_code) else $error("bad input claim");

    property p_claim_still;
        !$past(wb_cyc_i) && !$past(wb_cyc_i, 2) && !$past(wb_cyc_i, 3)
            |-> $stable(input_claim_o);
    endproperty
    a_claim_still: assert property (p_claim_still) else $error("claim moved alone");

    property p_unmapped_zero;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && (wb_adr_i > mmfc_pkg::ADDR_STATUS)
            |=> wb_dat_o == 32'h0000_0000;
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
endmodule

// *** test/mmfc_encoder.sv ***
`timescale 1ns/1ps

module mmfc_encoder (
    // clock
    input wire logic       clk_i,
    // stimulus control
    input wire logic       quad_i,
    input wire logic       step_i,
    input wire logic       dir_i,
    input wire logic [1:0] raw_i,
    // pins toward the counter
    output logic     [1:0] pins_o
);
    logic [1:0] ph = 2'b00;

    // one quarter step per request; tracks stay 90 degrees apart
    always_ff @(posedge clk_i) begin
        if (step_i) begin
            ph <= dir_i ? ph - 2'b01 : ph + 2'b01;
        end
    end

    // pin 0 is track A, pin 1 is track B; gray code keeps one edge per step
    assign pins_o = quad_i ? (ph ^ {1'b0, ph[1]}) : raw_i;
endmodule

// *** test/testbench.sv ***
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end

module testbench;
    logic        clk_i;
    logic        rst_i;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [3:0]  lanes;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic        ack;
    logic [1:0]  pins;
    logic [1:0]  raw;
    logic        quad;
    logic        step;
    logic        dir;
    logic        out;
    logic        oclaim;
    logic [1:0]  iclaim;
    logic [31:0] q;
    int          bad_count;
    int          checks_done;
    logic [3:0]  qm [3] = '{4'h7, 4'h9, 4'hA};
    logic [31:0] qk [3] = '{32'h1, 32'h2, 32'h4};
    logic [3:0]  om [3] = '{4'h0, 4'h8, 4'hB};

    mmfc_top DUT (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .input_channel_i(pins), .configurable_io_channel_o(out),
        .io_channel_claim_o(oclaim), .input_claim_o(iclaim));
    mmfc_encoder u_enc (.clk_i(clk_i), .quad_i(quad), .step_i(step), .dir_i(dir),
        .raw_i(raw), .pins_o(pins));

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // one classic cycle; read data is taken at the edge where ack is seen
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= lanes;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n >= 20) begin
            bad_count++;
            final_report();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000);
        `CHK(q, e)
    endtask

    task automatic claims(input logic [1:0] i, input logic o);
        tick(2);
        `CHK(iclaim, i)
        `CHK(oclaim, o)
    endtask

    // pin levels held well beyond the two-cycle minimum
    task automatic pin(input logic [1:0] v);
        @(posedge clk_i);
        raw <= v;
        tick(6);
    endtask

    task automatic pulse(input logic [1:0] m);
        pin(raw ^ m);
        pin(raw ^ m);
    endtask

    task automatic qs(input logic d, input int n);
        repeat (n) begin
            @(posedge clk_i);
            step <= 1'b1;
            dir <= d;
            @(posedge clk_i);
            step <= 1'b0;
            tick(6);
        end
    endtask

    initial begin
        rst_i = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'hF;
        lanes = 4'hF;
        wdat = 32'h0000_0000;
        raw = 2'b00;
        quad = 1'b0;
        step = 1'b0;
        dir = 1'b0;
        bad_count = 0;
        checks_done = 0;
        tick(3);
        rst_i <= 1'b0;
        rd(mmfc_pkg::ADDR_CTRL, 32'h0000_0000);
        rd(mmfc_pkg::ADDR_END0, 32'hFFFF_FFFF);
        rd(mmfc_pkg::ADDR_COUNT0, 32'h0000_0000);
        rd(mmfc_pkg::ADDR_STATUS, 32'h0000_0000);
        wr(8'h20, 32'hFFFF_FFFF);
        rd(8'h20, 32'h0000_0000);
        claims(2'b00, 1'b0);
        $display("test reset done");
        wr(mmfc_pkg::ADDR_END0, 32'h0000_0002);
        wr(mmfc_pkg::ADDR_CTRL, 32'h0000_0001);
        claims(2'b01, 1'b1);
        pulse(2'b01);
        rd(mmfc_pkg::ADDR_COUNT0, 32'h0000_0001);
        `CHK(out, 1'b0)
        pulse(2'b01);
        rd(mmfc_pkg::ADDR_STATUS, 32'h0000_0001);
        `CHK(out, 1'b1)
        wr(mmfc_pkg::ADDR_STATUS, 32'h0000_0001);
        claims(2'b01, 1'b1);
        `CHK(out, 1'b0)
        $display("test single up done");
        wr(mmfc_pkg::ADDR_CTRL, 32'h0000_0102);
        claims(2'b11, 1'b1);
        pulse(2'b01);
        rd(mmfc_pkg::ADDR_COUNT0, 32'h0000_0000);
        pin(2'b10);
        pulse(2'b01);
        rd(mmfc_pkg::ADDR_COUNT0, 32'h0000_0001);
        pin(2'b00);
        $display("test gated done");
        wr(mmfc_pkg::ADDR_CTRL, 32'h0000_0323);
        claims(2'b11, 1'b0);
        pulse(2'b01);
        pulse(2'b10);
        rd(mmfc_pkg::ADDR_COUNT0, 32'h0000_0001);
        rd(mmfc_pkg::ADDR_COUNT1, 32'hFFFF_FFFF);
        rd(mmfc_pkg::ADDR_STATUS, 32'h0000_0002);
        `CHK(out, 1'b0)
        wr(mmfc_pkg::ADDR_STATUS, 32'h0000_0007);
        wr(mmfc_pkg::ADDR_CTRL, 32'h0000_0304);
        pin(2'b10);
        rd(mmfc_pkg::ADDR_COUNT1, 32'h0000_0000);
        pin(2'b00);
        rd(mmfc_pkg::ADDR_COUNT1, 32'h0000_0001);
        $display("test dual done");
        wr(mmfc_pkg::ADDR_PRESET0, 32'h0000_0010);
        for (int m = 5; m < 7; m++) begin
            wr(mmfc_pkg::ADDR_CTRL, 32'h0000_0100 | m);
            claims(2'b11, 1'b0);
            pulse(2'b01);
            rd(mmfc_pkg::ADDR_COUNT0, 32'h0000_0011);
            pin(2'b10);
            rd(mmfc_pkg::ADDR_COUNT0, (m == 5) ? 32'h0000_0010 : 32'h0000_0011);
            pin(2'b00);
            rd(mmfc_pkg::ADDR_COUNT0, 32'h0000_0010);
            pulse(2'b01);
            rd(mmfc_pkg::ADDR_COUNT0, 32'h0000_0011);
            rd(mmfc_pkg::ADDR_STATUS, 32'h0000_0004);
            wr(mmfc_pkg::ADDR_STATUS, 32'h0000_0007);
        end
        $display("test dynamic set done");
        wr(mmfc_pkg::ADDR_PRESET0, 32'h0000_0000);
        @(posedge clk_i);
        quad <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            wr(mmfc_pkg::ADDR_END0, qk[i]);
            wr(mmfc_pkg::ADDR_STATUS, 32'h0000_0007);
            wr(mmfc_pkg::ADDR_CTRL, {28'h000_0010, qm[i]});
            claims(2'b11, 1'b0);
            qs(1'b0, 4);
            rd(mmfc_pkg::ADDR_COUNT0, qk[i]);
            rd(mmfc_pkg::ADDR_STATUS, 32'h0000_0001);
            `CHK(out, 1'b0)
            qs(1'b1, 8);
            rd(mmfc_pkg::ADDR_COUNT0, 32'h0000_0000 - qk[i]);
        end
        @(posedge clk_i);
        quad <= 1'b0;
        $display("test quadrature done");
        for (int i = 0; i < 3; i++) begin
            wr(mmfc_pkg::ADDR_CTRL, {28'h000_0000, om[i]});
            claims(2'b00, 1'b0);
            pulse(2'b01);
            pulse(2'b10);
            rd(mmfc_pkg::ADDR_COUNT0, 32'hFFFF_FFFC);
        end
        $display("test idle modes done");
        lanes = 4'h1;
        wr(mmfc_pkg::ADDR_PRESET1, 32'hFFFF_FFFF);
        lanes = 4'hF;
        rd(mmfc_pkg::ADDR_PRESET1, 32'h0000_00FF);
        @(posedge clk_i);
        rst_i <= 1'b1;
        tick(2);
        rst_i <= 1'b0;
        rd(mmfc_pkg::ADDR_COUNT0, 32'h0000_0000);
        rd(mmfc_pkg::ADDR_PRESET1, 32'h0000_0000);
        claims(2'b00, 1'b0);
        $display("test lanes and mid reset done");
        final_report();
    end
endmodule

bind mmfc_top mmfc_monitor u_mon (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .input_channel_i(input_channel_i),
    .configurable_io_channel_o(configurable_io_channel_o),
    .io_channel_claim_o(io_channel_claim_o), .input_claim_o(input_claim_o));
